// file: isp_consts.svh
// interrupt state and priority core: sizes, identifiers and priority constants
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH

`define ISP_NCPU 2
`define ISP_NSGI 2
`define ISP_NPPI 2
`define ISP_NBANK 4
`define ISP_NSPI 4
`define ISP_NLOC 8
`define ISP_IDX_W 3
`define ISP_ID_W 10
`define ISP_PRIO_W 8

// implemented priority bits; idle is the largest programmable value
`define ISP_PRIO_IMPL 8'hFF
`define ISP_IDLE_PRIO 8'hFF

`define ISP_SPURIOUS_ID 10'h3FF
`define ISP_SGI_ID_BASE 10'h000
`define ISP_PPI_ID_BASE 10'h010
`define ISP_SPI_ID_BASE 10'h020

`endif

// file: isp_pkg.sv
// interrupt state and priority core: shared types
`include "isp_consts.svh"

package isp_pkg;

    typedef enum logic [1:0] {
        ISP_INACTIVE = 2'b00,
        ISP_PENDING = 2'b01,
        ISP_ACTIVE = 2'b10,
        ISP_ACT_PEND = 2'b11
    } isp_state_t;

    typedef logic [`ISP_PRIO_W-1:0] isp_prio_t;
    typedef logic [`ISP_ID_W-1:0] isp_id_t;
    typedef logic [`ISP_IDX_W-1:0] isp_idx_t;

endpackage

// file: isp_view_if.sv
// interrupt state and priority core: per-processor view between core and arbiter
`include "isp_consts.svh"

interface isp_view_if;
    logic [`ISP_NLOC-1:0] cand;
    logic [`ISP_NLOC-1:0] actMine;
    logic [`ISP_NLOC-1:0][`ISP_PRIO_W-1:0] prio;
    logic selValid;
    logic [`ISP_IDX_W-1:0] selIdx;
    logic [`ISP_PRIO_W-1:0] runPrio;

    modport core (output cand, output actMine, output prio,
                  input selValid, input selIdx, input runPrio);
    modport arb (input cand, input actMine, input prio,
                 output selValid, output selIdx, output runPrio);
endinterface

// file: isp_cpu_arb.sv
// interrupt state and priority core: per-processor running priority and selection
`include "isp_consts.svh"

module isp_cpu_arb
    import isp_pkg::*;
(
    isp_view_if.arb view
);

    always_comb begin
        isp_prio_t run;
        isp_prio_t best;
        run = `ISP_IDLE_PRIO;
        best = `ISP_IDLE_PRIO;
        // running priority: most urgent active entry not yet ended, else idle
        for (int i = 0; i < `ISP_NLOC; i++) begin
            if (view.actMine[i] && (view.prio[i] < run)) begin
                run = view.prio[i];
            end
        end
        view.runPrio = run;
        // strict compare: ties go to the lowest index, and priority equal to
        // the running priority never preempts
        best = run;
        view.selValid = 1'b0;
        view.selIdx = '0;
        for (int i = 0; i < `ISP_NLOC; i++) begin
            if (view.cand[i] && (view.prio[i] < best)) begin
                best = view.prio[i];
                view.selValid = 1'b1;
                view.selIdx = isp_idx_t'(i);
            end
        end
    end

endmodule // isp_cpu_arb

// file: isp_core.sv
// interrupt state and priority core: interrupt states, banking, routing, acknowledge
`include "isp_consts.svh"

module isp_core
    import isp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`ISP_NCPU-1:0][`ISP_NPPI-1:0] privPeriphLine,
    input wire logic [`ISP_NSPI-1:0] sharedLine,
    input wire logic [`ISP_NCPU-1:0] swGenValid,
    input wire logic [`ISP_NCPU-1:0][`ISP_IDX_W-1:0] swGenIdx,
    input wire logic [`ISP_NCPU-1:0][`ISP_NCPU-1:0] swGenTargets,
    input wire logic [`ISP_NSPI-1:0] sharedSetPend,
    input wire logic [`ISP_NSPI-1:0] sharedClrPend,
    input wire logic [`ISP_NCPU-1:0][`ISP_NBANK-1:0][`ISP_PRIO_W-1:0] bankPrio,
    input wire logic [`ISP_NSPI-1:0][`ISP_PRIO_W-1:0] sharedPrio,
    input wire logic [`ISP_NCPU-1:0][`ISP_NBANK-1:0] bankGroup,
    input wire logic [`ISP_NSPI-1:0] sharedGroup,
    input wire logic [`ISP_NSPI-1:0][`ISP_NCPU-1:0] sharedTarget,
    input wire logic [`ISP_NCPU-1:0] ackReq,
    input wire logic [`ISP_NCPU-1:0] eoiReq,
    input wire logic [`ISP_NCPU-1:0][`ISP_ID_W-1:0] eoiId,
    output logic [`ISP_NCPU-1:0] irqOut,
    output logic [`ISP_NCPU-1:0] ackValid,
    output logic [`ISP_NCPU-1:0][`ISP_ID_W-1:0] ackId,
    output logic [`ISP_NCPU-1:0] ackGroup,
    output logic [`ISP_NCPU-1:0][`ISP_PRIO_W-1:0] runPrio,
    output isp_state_t [`ISP_NCPU-1:0][`ISP_NBANK-1:0] bankState,
    output isp_state_t [`ISP_NSPI-1:0] sharedState
);

    isp_state_t [`ISP_NCPU-1:0][`ISP_NBANK-1:0] bankState_reg, bankState_next;
    isp_state_t [`ISP_NSPI-1:0] sharedState_reg, sharedState_next;
    logic [`ISP_NSPI-1:0] sharedSoft_reg, sharedSoft_next;
    logic [`ISP_NSPI-1:0][`ISP_NCPU-1:0] sharedOwner_reg, sharedOwner_next;
    logic [`ISP_NCPU-1:0] irq_reg, irq_next;
    logic [`ISP_NCPU-1:0] ackValid_reg, ackValid_next;
    logic [`ISP_NCPU-1:0][`ISP_ID_W-1:0] ackId_reg, ackId_next;
    logic [`ISP_NCPU-1:0] ackGroup_reg, ackGroup_next;
    logic [`ISP_NCPU-1:0][`ISP_PRIO_W-1:0] runPrio_reg, runPrio_next;

    logic [`ISP_NCPU-1:0][`ISP_NLOC-1:0] pendView, actView, groupView;
    logic [`ISP_NCPU-1:0][`ISP_NLOC-1:0][`ISP_PRIO_W-1:0] prioView;
    logic [`ISP_NCPU-1:0] selValid;
    logic [`ISP_NCPU-1:0][`ISP_IDX_W-1:0] selIdx;
    logic [`ISP_NCPU-1:0][`ISP_PRIO_W-1:0] runPrioNow;
    logic [`ISP_NCPU-1:0][`ISP_NLOC-1:0] ackHot, eoiHot;

    isp_view_if viewBus[`ISP_NCPU] ();

    // local index map per processor: software ids, private ids, shared ids
    function automatic isp_id_t idOf(input isp_idx_t idx);
        isp_id_t id;
        if (idx < `ISP_NSGI) begin
            id = `ISP_SGI_ID_BASE + isp_id_t'(idx);
        end else if (idx < `ISP_NBANK) begin
            id = `ISP_PPI_ID_BASE + isp_id_t'(idx - `ISP_NSGI);
        end else begin
            id = `ISP_SPI_ID_BASE + isp_id_t'(idx - `ISP_NBANK);
        end
        return id;
    endfunction

    genvar c, k, j;
    generate
        for (c = 0; c < `ISP_NCPU; c++) begin : gCpu
            for (k = 0; k < `ISP_NBANK; k++) begin : gBank
                // banked entries see only this processor's instance
                assign pendView[c][k] = (bankState_reg[c][k] == ISP_PENDING);
                assign actView[c][k] = bankState_reg[c][k][1];
                assign prioView[c][k] = bankPrio[c][k] & `ISP_PRIO_IMPL;
                assign groupView[c][k] = bankGroup[c][k];
            end
            for (j = 0; j < `ISP_NSPI; j++) begin : gShared
                assign pendView[c][`ISP_NBANK+j] =
                    (sharedState_reg[j] == ISP_PENDING) && sharedTarget[j][c];
                assign actView[c][`ISP_NBANK+j] = sharedState_reg[j][1] && sharedOwner_reg[j][c];
                assign prioView[c][`ISP_NBANK+j] = sharedPrio[j] & `ISP_PRIO_IMPL;
                assign groupView[c][`ISP_NBANK+j] = sharedGroup[j];
            end
            assign viewBus[c].cand = pendView[c];
            assign viewBus[c].actMine = actView[c];
            assign viewBus[c].prio = prioView[c];
            assign selValid[c] = viewBus[c].selValid;
            assign selIdx[c] = viewBus[c].selIdx;
            assign runPrioNow[c] = viewBus[c].runPrio;

            isp_cpu_arb uArb (
                .view(viewBus[c].arb)
            );
        end
    endgenerate

    // acknowledge grants and end-of-interrupt decode
    always_comb begin
        logic taken;
        isp_id_t off;
        taken = 1'b0;
        off = '0;
        ackHot = '0;
        eoiHot = '0;
        for (int ci = 0; ci < `ISP_NCPU; ci++) begin
            if (ackReq[ci] && selValid[ci]) begin
                taken = 1'b1;
                // same shared interrupt taken by two processors: lower index wins
                for (int cj = 0; cj < ci; cj++) begin
                    if (ackReq[cj] && selValid[cj] && (selIdx[cj] == selIdx[ci]) &&
                        (selIdx[ci] >= `ISP_NBANK)) begin
                        taken = 1'b0;
                    end
                end
                ackHot[ci][selIdx[ci]] = taken;
            end
            if (eoiReq[ci]) begin
                off = eoiId[ci] - `ISP_SGI_ID_BASE;
                if (off < `ISP_NSGI) begin
                    eoiHot[ci][off[`ISP_IDX_W-1:0]] = 1'b1;
                end
                off = eoiId[ci] - `ISP_PPI_ID_BASE;
                if (off < `ISP_NPPI) begin
                    eoiHot[ci][`ISP_NSGI+off[`ISP_IDX_W-1:0]] = 1'b1;
                end
                off = eoiId[ci] - `ISP_SPI_ID_BASE;
                if (off < `ISP_NSPI) begin
                    eoiHot[ci][`ISP_NBANK+off[`ISP_IDX_W-1:0]] = 1'b1;
                end
            end
        end
    end

    // interrupt state transitions
    always_comb begin
        logic act, pend, actN, pendN, ackAny, eoiAny, swSet;
        act = 1'b0;
        pend = 1'b0;
        actN = 1'b0;
        pendN = 1'b0;
        ackAny = 1'b0;
        eoiAny = 1'b0;
        swSet = 1'b0;
        for (int ci = 0; ci < `ISP_NCPU; ci++) begin
            for (int ki = 0; ki < `ISP_NBANK; ki++) begin
                act = bankState_reg[ci][ki][1];
                pend = bankState_reg[ci][ki][0];
                if (ki < `ISP_NSGI) begin
                    // only processors with an interface here can raise these
                    swSet = 1'b0;
                    for (int si = 0; si < `ISP_NCPU; si++) begin
                        if (swGenValid[si] && swGenTargets[si][ci] &&
                            (swGenIdx[si] == isp_idx_t'(ki))) begin
                            swSet = 1'b1;
                        end
                    end
                    // a new request in the acknowledge cycle stays pending
                    pendN = (pend && !ackHot[ci][ki]) || swSet;
                end else begin
                    // level request: pending follows the line, so a dropped
                    // line before acknowledge yields the spurious id
                    pendN = privPeriphLine[ci][ki-`ISP_NSGI];
                end
                actN = (act && !eoiHot[ci][ki]) || ackHot[ci][ki];
                bankState_next[ci][ki] = isp_state_t'({actN, pendN});
            end
        end
        for (int ji = 0; ji < `ISP_NSPI; ji++) begin
            ackAny = 1'b0;
            eoiAny = 1'b0;
            sharedOwner_next[ji] = sharedOwner_reg[ji];
            for (int ci = 0; ci < `ISP_NCPU; ci++) begin
                ackAny = ackAny || ackHot[ci][`ISP_NBANK+ji];
                // only the processor that took it may end it
                eoiAny = eoiAny || (eoiHot[ci][`ISP_NBANK+ji] && sharedOwner_reg[ji][ci]);
            end
            act = sharedState_reg[ji][1];
            // set-pending may come from any observer, local or remote; set wins
            sharedSoft_next[ji] = (sharedSoft_reg[ji] && !ackAny && !sharedClrPend[ji]) ||
                                  sharedSetPend[ji];
            pendN = sharedLine[ji] || sharedSoft_next[ji];
            actN = (act && !eoiAny) || ackAny;
            sharedState_next[ji] = isp_state_t'({actN, pendN});
            if (ackAny) begin
                for (int ci = 0; ci < `ISP_NCPU; ci++) begin
                    sharedOwner_next[ji][ci] = ackHot[ci][`ISP_NBANK+ji];
                end
            end else if (!actN) begin
                sharedOwner_next[ji] = '0;
            end
        end
    end

    // acknowledge answers, request lines and running priority
    always_comb begin
        for (int ci = 0; ci < `ISP_NCPU; ci++) begin
            ackValid_next[ci] = ackReq[ci];
            ackId_next[ci] = `ISP_SPURIOUS_ID;
            ackGroup_next[ci] = 1'b0;
            if (ackReq[ci] && (ackHot[ci] != '0)) begin
                ackId_next[ci] = idOf(selIdx[ci]);
                ackGroup_next[ci] = groupView[ci][selIdx[ci]];
            end
            irq_next[ci] = selValid[ci];
            runPrio_next[ci] = runPrioNow[ci];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int ci = 0; ci < `ISP_NCPU; ci++) begin
                for (int ki = 0; ki < `ISP_NBANK; ki++) begin
                    bankState_reg[ci][ki] <= ISP_INACTIVE;
                end
            end
            for (int ji = 0; ji < `ISP_NSPI; ji++) begin
                sharedState_reg[ji] <= ISP_INACTIVE;
            end
            sharedSoft_reg <= '0;
            sharedOwner_reg <= '0;
            irq_reg <= '0;
            ackValid_reg <= '0;
            ackGroup_reg <= '0;
            for (int ci = 0; ci < `ISP_NCPU; ci++) begin
                ackId_reg[ci] <= `ISP_SPURIOUS_ID;
                runPrio_reg[ci] <= `ISP_IDLE_PRIO;
            end
        end else begin
            bankState_reg <= bankState_next;
            sharedState_reg <= sharedState_next;
            sharedSoft_reg <= sharedSoft_next;
            sharedOwner_reg <= sharedOwner_next;
            irq_reg <= irq_next;
            ackValid_reg <= ackValid_next;
            ackId_reg <= ackId_next;
            ackGroup_reg <= ackGroup_next;
            runPrio_reg <= runPrio_next;
        end
    end

    assign irqOut = irq_reg;
    assign ackValid = ackValid_reg;
    assign ackId = ackId_reg;
    assign ackGroup = ackGroup_reg;
    assign runPrio = runPrio_reg;
    assign bankState = bankState_reg;
    assign sharedState = sharedState_reg;

endmodule // isp_core

// file: isp_core_props.sv
// concurrent checks on the ports of the interrupt state and priority core
`include "isp_consts.svh"
module isp_core_props
    import isp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`ISP_NCPU-1:0] swGenValid,
    input wire logic [`ISP_NCPU-1:0][`ISP_IDX_W-1:0] swGenIdx,
    input wire logic [`ISP_NCPU-1:0][`ISP_NCPU-1:0] swGenTargets,
    input wire logic [`ISP_NSPI-1:0][`ISP_NCPU-1:0] sharedTarget,
    input wire logic [`ISP_NCPU-1:0] ackReq,
    input wire logic [`ISP_NCPU-1:0] eoiReq,
    input wire logic [`ISP_NCPU-1:0][`ISP_ID_W-1:0] eoiId,
    input wire logic [`ISP_NCPU-1:0] ackValid,
    input wire logic [`ISP_NCPU-1:0][`ISP_ID_W-1:0] ackId,
    input wire logic [`ISP_NCPU-1:0] ackGroup,
    input wire logic [`ISP_NCPU-1:0][`ISP_PRIO_W-1:0] runPrio,
    input wire isp_state_t [`ISP_NCPU-1:0][`ISP_NBANK-1:0] bankState,
    input wire isp_state_t [`ISP_NSPI-1:0] sharedState
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // shared actives may belong to either cpu, so any of them blocks idle
    logic noAct;
    always_comb begin
        noAct = 1'b1;
        for (int k = 0; k < `ISP_NBANK; k++)
            if (bankState[0][k][1]) noAct = 1'b0;
        for (int j = 0; j < `ISP_NSPI; j++)
            if (sharedState[j][1]) noAct = 1'b0;
    end
    a_reset_idle: assert property ($fell(rst) |-> runPrio[0] == `ISP_IDLE_PRIO &&
        bankState[1][3] == ISP_INACTIVE && ackId[1] == `ISP_SPURIOUS_ID) else $error("reset state");
    a_ack_timing: assert property (ackValid == $past(ackReq))
        else $error("acknowledge answer not one cycle after request");
    a_ack_active: assert property (ackValid[0] && ackId[0] == `ISP_SPI_ID_BASE
        |-> sharedState[0][1]) else $error("acknowledged shared interrupt not active");
    a_eoi_deact: assert property (eoiReq[0] && eoiId[0] == `ISP_PPI_ID_BASE &&
        bankState[0][2][1] |=> !bankState[0][2][1]) else $error("end of interrupt kept active");
    a_spi_route: assert property (ackValid[1] && ackId[1] == `ISP_SPI_ID_BASE
        |-> $past(sharedTarget[0][1])) else $error("shared interrupt to untargeted cpu");
    a_spur_group: assert property (ackValid[0] && ackId[0] == `ISP_SPURIOUS_ID
        |-> !ackGroup[0]) else $error("spurious answer with group one");
    a_ack_prio: assert property (ackValid[0] && ackId[0] != `ISP_SPURIOUS_ID
        |=> runPrio[0] != `ISP_IDLE_PRIO) else $error("running priority idle after acknowledge");
    a_idle_prio: assert property (noAct |=> runPrio[0] == `ISP_IDLE_PRIO)
        else $error("running priority not idle with nothing active");
    a_sgi_raise: assert property (swGenValid[0] && swGenIdx[0] == 3'h1 && swGenTargets[0][1]
        |=> bankState[1][1][0]) else $error("software interrupt not pending on target");
endmodule // isp_core_props

bind isp_core isp_core_props u_props (.core_clk, .rst, .swGenValid, .swGenIdx, .swGenTargets,
    .sharedTarget, .ackReq, .eoiReq, .eoiId, .ackValid, .ackId, .ackGroup, .runPrio,
    .bankState, .sharedState);

// file: isp_cpu_model.sv
// behavioural processor that acknowledges and ends interrupts on one cpu port
`include "isp_consts.svh"
module isp_cpu_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic irq,
    input wire logic poke,
    input wire logic [3:0] holdCycles,
    input wire logic ackValid,
    input wire logic [`ISP_ID_W-1:0] ackId,
    output logic ackReq = 1'b0,
    output logic eoiReq = 1'b0,
    output logic [`ISP_ID_W-1:0] eoiId = 10'h000
);
    timeunit 1ns;
    timeprecision 1ps;
    logic waiting = 1'b0;
    logic busy = 1'b0;
    logic [3:0] cnt = 4'h0;
    // one outstanding request; irqOut lags, so stale re-acks come back spurious
    always @(posedge core_clk) begin
        ackReq <= 1'b0;
        eoiReq <= 1'b0;
        if (rst) begin
            waiting <= 1'b0;
            busy <= 1'b0;
        end else if (ackValid) begin
            waiting <= 1'b0;
            busy <= ackId != `ISP_SPURIOUS_ID;
            eoiId <= ackId;
            cnt <= holdCycles;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h0) begin
                eoiReq <= 1'b1;
                busy <= 1'b0;
            end
        end else if (!waiting && (irq || poke)) begin
            ackReq <= 1'b1;
            waiting <= 1'b1;
        end
    end
endmodule // isp_cpu_model

// file: isp_core_tb_top.sv
// self-checking bench for the interrupt state and priority core
`include "isp_consts.svh"
module isp_core_tb_top
    import isp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [`ISP_NCPU-1:0][`ISP_NPPI-1:0] privPeriphLine = '0;
    logic [`ISP_NSPI-1:0] sharedLine = '0;
    logic [`ISP_NSPI-1:0] sharedSetPend = '0;
    logic [`ISP_NSPI-1:0] sharedClrPend = '0;
    logic [`ISP_NCPU-1:0] swGenValid = '0;
    logic [`ISP_NCPU-1:0][`ISP_IDX_W-1:0] swGenIdx = '0;
    logic [`ISP_NCPU-1:0][`ISP_NCPU-1:0] swGenTargets = '0;
    logic [`ISP_NCPU-1:0][`ISP_NBANK-1:0][`ISP_PRIO_W-1:0] bankPrio = '1;
    logic [`ISP_NSPI-1:0][`ISP_PRIO_W-1:0] sharedPrio = '1;
    logic [`ISP_NCPU-1:0][`ISP_NBANK-1:0] bankGroup = '0;
    logic [`ISP_NSPI-1:0] sharedGroup = '0;
    logic [`ISP_NSPI-1:0][`ISP_NCPU-1:0] sharedTarget = '0;
    logic [`ISP_NCPU-1:0] irqOut, ackValid, ackGroup, poke = '0;
    wire logic [`ISP_NCPU-1:0] ackReq, eoiReq;
    wire logic [`ISP_NCPU-1:0][`ISP_ID_W-1:0] eoiId;
    logic [`ISP_NCPU-1:0][`ISP_ID_W-1:0] ackId;
    logic [`ISP_NCPU-1:0][`ISP_PRIO_W-1:0] runPrio;
    logic [`ISP_NCPU-1:0][3:0] hold = '0;
    isp_state_t [`ISP_NCPU-1:0][`ISP_NBANK-1:0] bankState;
    isp_state_t [`ISP_NSPI-1:0] sharedState;
    int errors = 0;
    int cmpCount = 0;
    isp_core dut (.core_clk, .rst, .privPeriphLine, .sharedLine, .swGenValid, .swGenIdx,
        .swGenTargets, .sharedSetPend, .sharedClrPend, .bankPrio, .sharedPrio,
        .bankGroup, .sharedGroup, .sharedTarget, .ackReq, .eoiReq, .eoiId, .irqOut,
        .ackValid, .ackId, .ackGroup, .runPrio, .bankState, .sharedState);
    for (genvar c = 0; c < `ISP_NCPU; c++) begin : g_cpu
        isp_cpu_model cpu (.core_clk, .rst, .irq(irqOut[c]), .poke(poke[c]), .holdCycles(hold[c]),
            .ackValid(ackValid[c]), .ackId(ackId[c]), .ackReq(ackReq[c]), .eoiReq(eoiReq[c]),
            .eoiId(eoiId[c]));
    end
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic isp_state_t st(input int k, input int c, input int i);
        if (k == 1) return sharedState[i];
        return bankState[c][k == 0 ? i + 2 : i];
    endfunction
    function automatic logic [15:0] expId(input int k, input int i);
        return 16'(k == 0 ? `ISP_PPI_ID_BASE : k == 1 ? `ISP_SPI_ID_BASE : `ISP_SGI_ID_BASE) + 16'(i);
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // bounded wait; a miss shows up in the comparisons that follow
    task automatic wait_ack(input int c, input bit any);
        for (int n = 0; n < 60; n++) begin
            if (ackValid[c] === 1'b1 && (any || ackId[c] !== `ISP_SPURIOUS_ID)) break;
            step(1);
        end
    endtask
    // kind 0 private line, 1 shared line, 2 software; one source at a time
    task automatic run_one(input int k, input int c, input int i, input logic [7:0] p, input logic g);
        int s;
        s = k == 0 ? i + 2 : i;
        if (k == 1) begin
            sharedPrio[i] = p;
            sharedGroup[i] = g;
            sharedTarget[i] = 2'(1 << c);
            sharedLine[i] = 1'b1;
        end else begin
            bankPrio[c][s] = p;
            bankGroup[c][s] = g;
        end
        if (k == 0) privPeriphLine[c][i] = 1'b1;
        if (k == 2) begin
            swGenIdx[c] = 3'(i);
            swGenTargets[c] = 2'(1 << c);
            swGenValid[c] = 1'b1;
            step(1);
            swGenValid[c] = 1'b0;
        end
        wait_ack(c, 1'b0);
        check("ackId", 16'(ackId[c]), expId(k, i));
        check("ackGroup", 16'(ackGroup[c]), 16'(g));
        check("state at ack", 16'(st(k, c, i)), 16'(k == 2 ? ISP_ACTIVE : ISP_ACT_PEND));
        privPeriphLine = '0;
        sharedLine = '0;
        for (int n = 0; n < 60 && st(k, c, i) !== ISP_INACTIVE; n++) step(1);
        check("state after end", 16'(st(k, c, i)), 16'(ISP_INACTIVE));
        step(1);
        check("runPrio", 16'(runPrio[c]), 16'(`ISP_IDLE_PRIO));
        bankPrio = '1;
        sharedPrio = '1;
        $display("case kind %0d cpu %0d index %0d done", k, c, i);
    endtask
    initial begin
        #400000;
        errors++;
        stop_test();
    end
    initial begin
        void'($urandom(11085));
        step(4);
        rst = 1'b0;
        for (int c = 0; c < `ISP_NCPU; c++) begin
            check("reset runPrio", 16'(runPrio[c]), 16'(`ISP_IDLE_PRIO));
            check("reset ackId", 16'(ackId[c]), 16'(`ISP_SPURIOUS_ID));
            for (int b = 0; b < `ISP_NBANK; b++)
                check("reset bank", 16'(bankState[c][b]), 16'(ISP_INACTIVE));
        end
        $display("reset test done");
        // idle priority never signals; an acknowledge then finds nothing
        sharedTarget[3] = 2'b01;
        sharedLine[3] = 1'b1;
        step(8);
        check("irq at idle prio", 16'(irqOut[0]), 16'h0000);
        check("pending by line", 16'(sharedState[3]), 16'(ISP_PENDING));
        poke[0] = 1'b1;
        step(1);
        poke[0] = 1'b0;
        wait_ack(0, 1'b1);
        check("spurious id", 16'(ackId[0]), 16'(`ISP_SPURIOUS_ID));
        check("spurious group", 16'(ackGroup[0]), 16'h0000);
        sharedLine[3] = 1'b0;
        $display("idle priority test done");
        // one software id to both cpus; slow cpu keeps its own copy active
        hold = {4'hF, 4'h0};
        bankPrio[0][1] = 8'h10;
        bankPrio[1][1] = 8'h10;
        swGenIdx[0] = 3'h1;
        swGenTargets[0] = 2'b11;
        swGenValid[0] = 1'b1;
        step(1);
        swGenValid[0] = 1'b0;
        step(10);
        check("fast cpu copy", 16'(bankState[0][1]), 16'(ISP_INACTIVE));
        check("slow cpu copy", 16'(bankState[1][1]), 16'(ISP_ACTIVE));
        step(25);
        check("slow cpu ended", 16'(bankState[1][1]), 16'(ISP_INACTIVE));
        bankPrio = '1;
        $display("banked test done");
        // remote set-pending to both cpus: both ack in one edge, lower index takes it
        hold[0] = 4'h0;
        sharedPrio[1] = 8'h20;
        sharedTarget[1] = 2'b11;
        sharedSetPend[1] = 1'b1;
        step(1);
        sharedSetPend[1] = 1'b0;
        wait_ack(0, 1'b0);
        check("shared winner id", 16'(ackId[0]), 16'(`ISP_SPI_ID_BASE) + 16'h0001);
        check("loser answered", 16'(ackValid[1]), 16'h0001);
        check("shared loser id", 16'(ackId[1]), 16'(`ISP_SPURIOUS_ID));
        check("shared taken", 16'(sharedState[1]), 16'(ISP_ACTIVE));
        // set beats clear in one cycle; clear alone then drops it
        sharedSetPend[2] = 1'b1;
        sharedClrPend[2] = 1'b1;
        step(1);
        sharedSetPend[2] = 1'b0;
        check("set beats clear", 16'(sharedState[2]), 16'(ISP_PENDING));
        step(1);
        sharedClrPend[2] = 1'b0;
        check("clear pending", 16'(sharedState[2]), 16'(ISP_INACTIVE));
        step(10);
        check("shared ended", 16'(sharedState[1]), 16'(ISP_INACTIVE));
        sharedPrio = '1;
        $display("shared access test done");
        // corners: shared 0 on each cpu, first private line on cpu 0
        run_one(1, 0, 0, 8'h40, 1'b1);
        run_one(1, 1, 0, 8'h40, 1'b0);
        run_one(0, 0, 0, 8'h01, 1'b1);
        for (int t = 0; t < 30; t++) begin
            int k;
            int c;
            k = $urandom % 3;
            c = $urandom % 2;
            hold[c] = 4'($urandom % 8);
            run_one(k, c, $urandom % (k == 1 ? 3 : 2), 8'($urandom % 255), 1'($urandom));
        end
        stop_test();
    end
endmodule // isp_core_tb_top
